/* inc/sesu_pkg.sv */
package sesu_pkg;
  localparam int AW   = 4;
  localparam int DW   = 16;
  localparam int NEVT = 15;
  localparam int NPIN = 2;
  localparam int NSRC = 5;
  // ************************************************************
  // Register offsets and fields
  // ************************************************************
  localparam logic [AW-1:0] REG_FLAG  = 4'h0;
  localparam logic [AW-1:0] REG_MASKA = 4'h1;
  localparam logic [AW-1:0] REG_MASKB = 4'h2;
  localparam logic [AW-1:0] REG_BINDX = 4'h3;
  localparam logic [AW-1:0] REG_BINDY = 4'h4;
  localparam logic [AW-1:0] REG_PIN0  = 4'h5;
  localparam logic [AW-1:0] REG_PIN1  = 4'h6;
  localparam logic [AW-1:0] REG_STAT  = 4'h7;
  localparam int EN_BIT  = 15;
  localparam int POL_BIT = 14;
  localparam int EVT_LSB = 8;
  localparam logic [DW-1:0] RST_REG = 16'h0000;
  // ************************************************************
  // Opcodes
  // ************************************************************
  localparam logic [7:0] OP_NOOP  = 8'h00;
  localparam logic [7:0] OP_CRYSTAL_OSCILLATOR  = 8'h01;
  localparam logic [7:0] OP_BUFLD = 8'h02;
  localparam logic [7:0] OP_BUFEX = 8'h03;
  localparam logic [7:0] OP_OFF   = 8'h04;
  localparam logic [7:0] OP_RXON  = 8'h05;
  localparam logic [7:0] OP_TXON  = 8'h06;
  localparam logic [7:0] STB_HI   = 8'h3F;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  typedef struct packed {
    logic crystal_oscillator_ok;
    logic signal_strength_ok;
    logic dpu_h;
    logic dpu_l;
    logic tx;
    logic rx;
  } sesu_stat_s;
  typedef struct packed {
    logic radio_idle;
    logic tx_frm_ok;
    logic tx_ack_ok;
    logic tx_under;
    logic tx_over;
    logic rx_under;
    logic rx_over;
    logic rxen_zero;
    logic frame_received_event;
    logic rx_frm_acc;
    logic match_en;
    logic match_done;
    logic match_hit;
    logic rx_thresh;
    logic rx_frm_stored;
    logic rx_over_state;
    logic sfd;
    logic dpu_done_l;
  } sesu_evt_s;
  typedef struct packed {
    logic       vld;
    logic [7:0] code;
  } sesu_strobe_s;
  typedef enum logic [1:0] {SP_OP, SP_ARG, SP_SKIP} sesu_spi_e;
endpackage

/* hdl/sesu_core.sv */
`timescale 1ns/1ps
module sesu_core
  import sesu_pkg::*;
(
  input  wire logic               i_core_clk,
  input  wire logic               i_reset,
  input  wire logic               i_chip_select_low,
  input  wire logic               i_sclk,
  input  wire logic               i_si,
  output logic                    o_so,
  output logic                    o_so_oe,
  input  wire logic [NPIN-1:0]    i_strobe_pin,
  input  wire logic [AW-1:0]      i_addr,
  input  wire logic [DW-1:0]      i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic [DW-1:0]           o_rdata,
  input  wire sesu_stat_s         i_stat,
  input  wire sesu_evt_s          i_evt,
  output sesu_strobe_s            o_strobe,
  output logic                    o_crystal_oscillator_on,
  output logic                    o_chan_a,
  output logic                    o_chan_a_cmp,
  output logic                    o_chan_b,
  output logic                    o_chan_b_cmp
);
  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic is_strobe(input logic [7:0] c);
    is_strobe = (c != OP_NOOP) && (c != OP_CRYSTAL_OSCILLATOR) &&
                (c != OP_BUFLD) && (c <= STB_HI);
  endfunction

  function automatic logic [NSRC-1:0] first_one(
    input logic [NSRC-1:0] v);
    first_one = v & (~v + NSRC'(1));
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  logic [NEVT-1:0] flag_r;
  logic [NEVT-1:0] flag_nxt;
  logic [NEVT-1:0] mask_a_r;
  logic [NEVT-1:0] mask_b_r;
  logic [DW-1:0]   bind_x_r;
  logic [DW-1:0]   bind_y_r;
  logic [DW-1:0]   pin0_r;
  logic [DW-1:0]   pin1_r;
  logic [7:0]      buf_r;
  logic [7:0]      buf_nxt;
  logic [NSRC-1:0] pend_r;
  logic [NSRC-1:0] pend_nxt;
  logic [7:0]      pcode_r [NSRC];
  logic            idle_q_r;
  logic            rxen_q_r;
  logic            abort_r;

  // ************************************************************
  // Serial port and strobe pin synchronisers
  // ************************************************************
  logic [2:0] cs_s_r;
  logic [2:0] ck_s_r;
  logic [1:0] si_s_r;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  logic [NPIN-1:0] pin_s3_r;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      cs_s_r   <= 3'h7;
      ck_s_r   <= 3'h0;
      si_s_r   <= 2'h0;
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end else begin
      cs_s_r   <= {cs_s_r[1:0], i_chip_select_low};
      ck_s_r   <= {ck_s_r[1:0], i_sclk};
      si_s_r   <= {si_s_r[0], i_si};
      pin_s1_r <= i_strobe_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // Only stage 1 and later are looked at; stage 0 feeds stage 1 only
  wire cs_act  = ~cs_s_r[1];
  wire cs_fall = cs_s_r[2] & ~cs_s_r[1];
  wire ck_rise = cs_act & ~ck_s_r[2] & ck_s_r[1];
  wire ck_fall = cs_act & ck_s_r[2] & ~ck_s_r[1];
  wire si_bit  = si_s_r[1];

  // ************************************************************
  // Status byte
  // ************************************************************
  wire [7:0] status_byte = {
    i_stat.crystal_oscillator_ok, i_stat.signal_strength_ok,
    |(flag_r & mask_a_r), |(flag_r & mask_b_r),
    i_stat.dpu_h, i_stat.dpu_l,
    i_stat.tx, i_stat.rx
  };

  // ************************************************************
  // Serial shifter
  // ************************************************************
  logic [7:0] tx_sh_r;
  logic [7:0] rx_sh_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] op_r;
  sesu_spi_e  sp_st_r;
  sesu_spi_e  sp_st_nxt;

  wire       byte_end  = ck_rise && (bit_cnt_r == BYTE_BITS - 4'h1);
  wire [7:0] byte_val  = {rx_sh_r[6:0], si_bit};
  wire       load_stat = cs_fall | (ck_fall && bit_cnt_r == BYTE_BITS);

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_sh_r   <= 8'h00;
      rx_sh_r   <= 8'h00;
      bit_cnt_r <= 4'h0;
      o_so      <= 1'b0;
    end else if (cs_fall) begin
      tx_sh_r   <= {status_byte[6:0], 1'b0};
      o_so      <= status_byte[7];
      bit_cnt_r <= 4'h0;
    end else if (load_stat) begin
      tx_sh_r   <= {status_byte[6:0], 1'b0};
      o_so      <= status_byte[7];
      bit_cnt_r <= 4'h0;
    end else if (ck_fall) begin
      tx_sh_r   <= {tx_sh_r[6:0], 1'b0};
      o_so      <= tx_sh_r[7];
    end else if (ck_rise) begin
      rx_sh_r   <= byte_val;
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  assign o_so_oe = cs_act;

  // Later bytes of long instructions belong to other blocks
  always_comb begin
    sp_st_nxt = sp_st_r;
    if (!cs_act) begin
      sp_st_nxt = SP_OP;
    end else if (byte_end) begin
      case (sp_st_r)
        SP_OP:   sp_st_nxt = (byte_val == OP_BUFLD) ? SP_ARG
                                                   : SP_SKIP;
        SP_ARG:  sp_st_nxt = SP_SKIP;
        SP_SKIP: sp_st_nxt = SP_SKIP;
        default: sp_st_nxt = SP_SKIP;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      sp_st_r <= SP_OP;
      op_r    <= OP_NOOP;
    end else begin
      sp_st_r <= sp_st_nxt;
      if (byte_end && sp_st_r == SP_OP) begin
        op_r <= byte_val;
      end
    end
  end

  wire op_end   = byte_end && sp_st_r == SP_OP;
  wire spi_stb  = op_end && is_strobe(byte_val);
  wire spi_crystal_oscillator = op_end && byte_val == OP_CRYSTAL_OSCILLATOR;
  wire buf_load = byte_end && sp_st_r == SP_ARG &&
                  op_r == OP_BUFLD;

  // ************************************************************
  // Events and flags
  // ************************************************************
  logic [NEVT-1:0] evt_set;
  // Driven below, once the strobe about to issue is known
  logic            tx_block;
  wire m_en      = i_evt.match_en;

  // Bit index is the event code, shared with the binding selectors
  always_comb begin
    evt_set     = '0;
    evt_set[0]  = i_evt.radio_idle & ~idle_q_r;
    evt_set[1]  = i_evt.tx_frm_ok & ~tx_block;
    evt_set[2]  = i_evt.tx_ack_ok & ~tx_block;
    evt_set[3]  = i_evt.tx_under;
    evt_set[4]  = i_evt.tx_over;
    evt_set[5]  = i_evt.rx_under;
    evt_set[6]  = i_evt.rx_over;
    evt_set[7]  = i_evt.rxen_zero & ~rxen_q_r;
    evt_set[8]  = i_evt.frame_received_event;
    evt_set[9]  = i_evt.rx_frm_acc;
    evt_set[10] = m_en & i_evt.match_done;
    evt_set[11] = m_en & i_evt.match_hit;
    evt_set[12] = i_evt.rx_thresh | i_evt.rx_frm_stored |
                  i_evt.rx_over_state;
    evt_set[13] = i_evt.sfd;
    evt_set[14] = i_evt.dpu_done_l;
  end

  wire wr_flag = i_wr && i_addr == REG_FLAG;
  // Set beats clear when both land on the same edge
  assign flag_nxt = (wr_flag ? (flag_r & i_wdata[NEVT-1:0]) : flag_r)
                    | evt_set;

  // ************************************************************
  // Strobe sources and arbitration
  // ************************************************************
  logic [NSRC-1:0] req;
  logic [7:0]      req_code [NSRC];
  logic [NPIN-1:0] pin_edge;
  logic [DW-1:0]   pin_cfg [NPIN];

  assign pin_cfg[0] = pin0_r;
  assign pin_cfg[1] = pin1_r;

  always_comb begin
    for (int k = 0; k < NPIN; k++) begin
      pin_edge[k] = pin_cfg[k][EN_BIT] &&
        (pin_cfg[k][POL_BIT] ? (pin_s2_r[k] & ~pin_s3_r[k])
                             : (~pin_s2_r[k] & pin_s3_r[k]));
    end
  end

  wire [3:0] bx_evt = bind_x_r[EVT_LSB+3:EVT_LSB];
  wire [3:0] by_evt = bind_y_r[EVT_LSB+3:EVT_LSB];
  wire bx_hit = bind_x_r[EN_BIT] && bx_evt < 4'(NEVT) &&
                evt_set[bx_evt];
  wire by_hit = bind_y_r[EN_BIT] && by_evt < 4'(NEVT) &&
                evt_set[by_evt];

  always_comb begin
    req         = {by_hit, bx_hit, pin_edge, spi_stb};
    req_code[0] = byte_val;
    req_code[1] = pin0_r[7:0];
    req_code[2] = pin1_r[7:0];
    req_code[3] = bind_x_r[7:0];
    req_code[4] = bind_y_r[7:0];
  end

  // Serial port wins; lower sources wait a cycle for each source granted ahead of them; a repeat request while pending merges into one with the latest code
  wire [NSRC-1:0] grant = first_one(pend_r);
  logic [7:0] sel_code;

  always_comb begin
    sel_code = OP_NOOP;
    for (int k = 0; k < NSRC; k++) begin
      if (grant[k]) begin
        sel_code = pcode_r[k];
      end
    end
  end

  assign pend_nxt = (pend_r & ~grant) | req;

  // ************************************************************
  // Strobe buffer and execution
  // ************************************************************
  wire       buf_ex  = |grant && sel_code == OP_BUFEX;
  wire [7:0] run_code = buf_ex ? buf_r : sel_code;
  // Oscillator-on never runs from the buffer or a pin or binding
  wire o_strobe_nxt_vld = |grant && is_strobe(run_code) &&
                          run_code != OP_BUFEX;
  wire abort_now = o_strobe_nxt_vld &&
                   (run_code == OP_OFF || run_code == OP_RXON ||
                    run_code == OP_TXON);
  assign tx_block = abort_now | abort_r;

  always_comb begin
    buf_nxt = buf_r;
    if (buf_ex) begin
      buf_nxt = OP_NOOP;
    end else if (buf_load) begin
      buf_nxt = byte_val;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      pend_r   <= '0;
      buf_r    <= OP_NOOP;
      o_strobe <= '0;
      o_crystal_oscillator_on <= 1'b0;
      abort_r  <= 1'b0;
      idle_q_r <= 1'b1;
      rxen_q_r <= 1'b1;
      for (int k = 0; k < NSRC; k++) begin
        pcode_r[k] <= OP_NOOP;
      end
    end else begin
      pend_r    <= pend_nxt;
      buf_r     <= buf_nxt;
      o_strobe  <= '{vld: o_strobe_nxt_vld, code: run_code};
      o_crystal_oscillator_on <= spi_crystal_oscillator;
      abort_r   <= abort_now;
      idle_q_r  <= i_evt.radio_idle;
      rxen_q_r  <= i_evt.rxen_zero;
      for (int k = 0; k < NSRC; k++) begin
        if (req[k]) begin
          pcode_r[k] <= req_code[k];
        end
      end
    end
  end

  // ************************************************************
  // Register file
  // ************************************************************
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      flag_r   <= '0;
      mask_a_r <= '0;
      mask_b_r <= '0;
      bind_x_r <= RST_REG;
      bind_y_r <= RST_REG;
      pin0_r   <= RST_REG;
      pin1_r   <= RST_REG;
    end else begin
      flag_r <= flag_nxt;
      if (i_wr) begin
        case (i_addr)
          REG_MASKA: mask_a_r <= i_wdata[NEVT-1:0];
          REG_MASKB: mask_b_r <= i_wdata[NEVT-1:0];
          REG_BINDX: bind_x_r <= i_wdata;
          REG_BINDY: bind_y_r <= i_wdata;
          REG_PIN0:  pin0_r   <= i_wdata;
          REG_PIN1:  pin1_r   <= i_wdata;
          default:   ;
        endcase
      end
    end
  end

  logic [DW-1:0] rd_mux;

  always_comb begin
    case (i_addr)
      REG_FLAG:  rd_mux = {1'b0, flag_r};
      REG_MASKA: rd_mux = {1'b0, mask_a_r};
      REG_MASKB: rd_mux = {1'b0, mask_b_r};
      REG_BINDX: rd_mux = bind_x_r;
      REG_BINDY: rd_mux = bind_y_r;
      REG_PIN0:  rd_mux = pin0_r;
      REG_PIN1:  rd_mux = pin1_r;
      REG_STAT:  rd_mux = {buf_r, status_byte};
      default:   rd_mux = RST_REG;
    endcase
  end

  // ************************************************************
  // Read data and channel outputs
  // ************************************************************
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata      <= RST_REG;
      o_chan_a     <= 1'b0;
      o_chan_a_cmp <= 1'b0;
      o_chan_b     <= 1'b0;
      o_chan_b_cmp <= 1'b0;
    end else begin
      o_rdata      <= i_rd ? rd_mux : RST_REG;
      o_chan_a     <= |(flag_r & mask_a_r);
      o_chan_a_cmp <= |(flag_r & ~mask_a_r);
      o_chan_b     <= |(flag_r & mask_b_r);
      o_chan_b_cmp <= |(flag_r & ~mask_b_r);
    end
  end
endmodule

/* tb/sesu_core_properties.sv */
`timescale 1ns/1ps
module sesu_core_checker
  import sesu_pkg::*;
(
  input wire logic          i_core_clk,
  input wire logic          i_reset,
  input wire logic          i_chip_select_low,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic          i_wr,
  input wire logic          i_rd,
  input wire logic [DW-1:0] o_rdata,
  input wire sesu_stat_s    i_stat,
  input wire sesu_evt_s     i_evt,
  input wire sesu_strobe_s  o_strobe,
  input wire logic          o_crystal_oscillator_on,
  input wire logic          o_so_oe
);
  // ****************************************
  // Checks at the ports
  // ****************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  // Match enable is a level qualifier, not an event of its own
  wire quiet   = ({i_evt[17:8], i_evt[6:0]} == '0);
  wire rd_flag = i_rd && (i_addr == REG_FLAG);
  wire rd_stat = i_rd && (i_addr == REG_STAT);
  wire wr_flag = i_wr && (i_addr == REG_FLAG);

  a_rdata_rest: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data not zero between answers");
  a_flag_top: assert property ($past(rd_flag) |-> !o_rdata[15])
    else $error("flag word bit 15 set");
  a_status_read: assert property (
    $past(rd_stat) && ($past(i_stat) == $past(i_stat, 2))
    |-> {o_rdata[7:6], o_rdata[3:0]} == $past(i_stat))
    else $error("status byte differs from status inputs");
  a_strobe_legal: assert property (o_strobe.vld |->
    o_strobe.code != OP_NOOP && o_strobe.code != OP_CRYSTAL_OSCILLATOR &&
    o_strobe.code != OP_BUFLD && o_strobe.code <= STB_HI)
    else $error("illegal strobe code issued");
  a_crystal_oscillator_serial: assert property (
    o_crystal_oscillator_on |-> !i_chip_select_low ##1 !o_crystal_oscillator_on)
    else $error("oscillator-on pulse outside a serial frame");
  a_oe_release: assert property (i_chip_select_low [*4] |-> !o_so_oe)
    else $error("serial output driven while deselected");
  a_oe_drive: assert property (!i_chip_select_low [*4] |-> o_so_oe)
    else $error("serial output not driven while selected");
  a_flag_clear: assert property (
    wr_flag && i_wdata == '0 && quiet ##1 quiet ##1 rd_flag
    |=> o_rdata == '0)
    else $error("flags not cleared by zero write");
  a_flag_keep: assert property (
    wr_flag && !i_wdata[4] && i_evt.tx_over ##1 !wr_flag ##1 rd_flag
    |=> o_rdata[4])
    else $error("flag lost to a same-cycle clear");
  a_flag_sets: assert property (
    i_evt.sfd ##1 !wr_flag ##1 rd_flag |=> o_rdata[13])
    else $error("event flag not set in detection cycle");
endmodule

bind sesu_core sesu_core_checker chk_u (
  .i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_chip_select_low(i_chip_select_low), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_stat(i_stat), .i_evt(i_evt), .o_strobe(o_strobe),
  .o_crystal_oscillator_on(o_crystal_oscillator_on), .o_so_oe(o_so_oe)
);

/* tb/sesu_host.sv */
`timescale 1ns/1ps
module sesu_host
  import sesu_pkg::*;
(
  output logic      o_chip_select_low,
  output logic      o_sclk,
  output logic      o_si,
  input  wire logic i_so
);
  // ****************************************
  // Serial master, link clock 200 ns
  // ****************************************
  initial begin
    o_chip_select_low = 1'b1;
    o_sclk = 1'b0;
    o_si = 1'b1;
  end

  // Link clock stands low outside frames; data shifts on the falling edge
  task automatic xfer(input logic [7:0] op, input logic [7:0] arg,
                      input logic two, output logic [7:0] st);
    o_chip_select_low = 1'b0;
    #200;
    for (int i = 0; i < (two ? 16 : 8); i++) begin
      o_si = (i < 8) ? op[7-i] : arg[15-i];
      #100 o_sclk = 1'b1;
      if (i < 8) st[7-i] = i_so;
      #100 o_sclk = 1'b0;
    end
    #200 o_chip_select_low = 1'b1;
    // Released line must not keep showing the last bit
    o_si = ~o_si;
    #400;
  endtask
endmodule

/* tb/test_status_exception_strobe_unit.sv */
`timescale 1ns/1ps
module test_status_exception_strobe_unit
  import sesu_pkg::*;
;
  localparam int POS [17] = '{17, 16, 15, 14, 13, 12, 11, 10, 9, 8, 6, 5,
                              4, 3, 2, 1, 0};
  localparam int CODE [17] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12,
                               12, 12, 13, 14};
  logic            clk;
  logic            rst;
  logic            chip_select_low;
  logic            sclk;
  logic            si;
  logic            so;
  logic [NPIN-1:0] pin;
  logic [AW-1:0]   addr;
  logic [DW-1:0]   wdata;
  logic [DW-1:0]   rdata;
  logic            wr;
  logic            rd;
  logic            xon;
  logic [3:0]      chan;
  sesu_stat_s      stat;
  sesu_evt_s       evt;
  sesu_evt_s       base;
  sesu_strobe_s    stb;
  logic [255:0]    seen;
  logic            seen_clr;
  int              xcnt;
  int              mismatches;
  int              n_compared;

  sesu_core dut_u (
    .i_core_clk(clk), .i_reset(rst), .i_chip_select_low(chip_select_low),
    .i_sclk(sclk), .i_si(si), .o_so(so), .o_so_oe(),
    .i_strobe_pin(pin), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_stat(stat), .i_evt(evt),
    .o_strobe(stb), .o_crystal_oscillator_on(xon), .o_chan_a(chan[3]),
    .o_chan_a_cmp(chan[2]), .o_chan_b(chan[1]), .o_chan_b_cmp(chan[0])
  );
  sesu_host host_u (
    .o_chip_select_low(chip_select_low), .o_sclk(sclk), .o_si(si), .i_so(so)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  always @(posedge clk) begin
    if (rst || seen_clr) seen <= '0;
    else if (stb.vld) seen[stb.code] <= 1'b1;
    if (rst) xcnt <= 0;
    else if (xon) xcnt <= xcnt + 1;
  end

  // Forget strobes seen so far; ends just after a clock edge
  task automatic clr();
    @(posedge clk) seen_clr <= 1'b1;
    @(posedge clk) seen_clr <= 1'b0;
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One register cycle; e rides on the event inputs for that cycle
  task automatic bus(input logic w, input logic [AW-1:0] a,
                     input logic [DW-1:0] d, input sesu_evt_s e,
                     output logic [DW-1:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    evt <= e;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    evt <= base;
    #1 q = rdata;
  endtask

  task automatic expect_stb(input logic [7:0] c, input logic want);
    for (int i = 0; i < 20 && !seen[c]; i++) @(posedge clk);
    #1 chk(16'(seen[c]), 16'(want));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [15:0] q;
    for (int a = 0; a < 9; a++) begin
      bus(0, 4'(a), 16'h0000, base, q);
      chk(q, RST_REG);
    end
    bus(1, REG_STAT, 16'hFFFF, base, q);
    bus(0, REG_STAT, 16'h0000, base, q);
    chk(q, 16'h0000);
    $display("reset test done");
  endtask

  task automatic t_flags();
    logic [15:0] q;
    sesu_evt_s   p;
    for (int i = 0; i < 17; i++) begin
      p = base;
      p[POS[i]] = 1'b1;
      bus(1, 4'hF, 16'hFFFF, p, q);
      bus(0, REG_FLAG, 16'h0000, base, q);
      chk(q, 16'h0001 << CODE[i]);
      bus(1, REG_FLAG, 16'h0000, base, q);
      bus(0, REG_FLAG, 16'h0000, base, q);
      chk(q, 16'h0000);
    end
    p = base;
    p.match_en = 1'b0;
    p.match_done = 1'b1;
    bus(1, 4'hF, 16'hFFFF, p, q);
    bus(0, REG_FLAG, 16'h0000, base, q);
    chk(q, 16'h0000);
    p = base;
    p.tx_over = 1'b1;
    bus(1, REG_FLAG, 16'h0000, p, q);
    bus(0, REG_FLAG, 16'h0000, base, q);
    chk(q, 16'h0010);
    bus(1, REG_FLAG, 16'h7FFF, base, q);
    bus(0, REG_FLAG, 16'h0000, base, q);
    chk(q, 16'h0010);
    bus(1, REG_MASKA, 16'h0010, base, q);
    bus(1, REG_MASKB, 16'h0001, base, q);
    bus(0, REG_STAT, 16'h0000, base, q);
    chk({12'h000, chan}, 16'h0009);
    chk(q & 16'h0030, 16'h0020);
    $display("flag test done");
  endtask

  task automatic t_status();
    logic [7:0] b;
    sesu_stat_s s [3] = '{6'h2A, 6'h15, 6'h3F};
    for (int i = 0; i < 3; i++) begin
      clr();
      @(posedge clk) stat <= s[i];
      // Keep serial pin changes off the core clock edge
      #1 host_u.xfer(OP_NOOP, 8'h00, 1'b0, b);
      chk({8'h00, b}, {8'h00, s[i][5:4], 2'b10, s[i][3:0]});
      chk(16'(seen != '0), 16'h0000);
    end
    $display("status test done");
  endtask

  task automatic t_strobes();
    logic [7:0] b;
    logic [7:0] ops [4] = '{OP_OFF, OP_RXON, OP_TXON, STB_HI};
    int         x;
    foreach (ops[i]) begin
      clr();
      host_u.xfer(ops[i], 8'h00, 1'b0, b);
      expect_stb(ops[i], 1'b1);
    end
    x = xcnt;
    clr();
    host_u.xfer(OP_CRYSTAL_OSCILLATOR, 8'h00, 1'b0, b);
    chk(16'(xcnt - x), 16'h0001);
    chk(16'(seen != '0), 16'h0000);
    $display("strobe test done");
  endtask

  task automatic t_buffer();
    logic [7:0]  b;
    logic [15:0] q;
    int          x;
    host_u.xfer(OP_BUFLD, OP_TXON, 1'b1, b);
    bus(0, REG_STAT, 16'h0000, base, q);
    chk(q >> 8, 16'(OP_TXON));
    clr();
    host_u.xfer(OP_BUFEX, 8'h00, 1'b0, b);
    expect_stb(OP_TXON, 1'b1);
    bus(0, REG_STAT, 16'h0000, base, q);
    chk(q >> 8, 16'h0000);
    clr();
    host_u.xfer(OP_BUFEX, 8'h00, 1'b0, b);
    expect_stb(OP_TXON, 1'b0);
    x = xcnt;
    host_u.xfer(OP_BUFLD, OP_CRYSTAL_OSCILLATOR, 1'b1, b);
    host_u.xfer(OP_BUFEX, 8'h00, 1'b0, b);
    chk(16'(xcnt - x), 16'h0000);
    $display("buffer test done");
  endtask

  task automatic t_pins();
    logic [15:0] q;
    bus(1, REG_PIN0, {8'hC0, OP_TXON}, base, q);
    bus(1, REG_PIN1, {8'h80, OP_RXON}, base, q);
    clr();
    @(posedge clk) pin <= 2'b01;
    expect_stb(OP_TXON, 1'b1);
    @(posedge clk) pin <= 2'b11;
    expect_stb(OP_RXON, 1'b0);
    clr();
    @(posedge clk) pin <= 2'b00;
    expect_stb(OP_RXON, 1'b1);
    expect_stb(OP_TXON, 1'b0);
    $display("pin test done");
  endtask

  task automatic t_bind();
    logic [7:0]  b;
    logic [15:0] q;
    sesu_evt_s   p;
    host_u.xfer(OP_BUFLD, OP_TXON, 1'b1, b);
    bus(1, REG_BINDX, {8'h89, OP_OFF}, base, q);
    bus(1, REG_BINDY, {8'h8E, OP_BUFEX}, base, q);
    clr();
    p = base;
    p.rx_frm_acc = 1'b1;
    bus(1, 4'hF, 16'h0000, p, q);
    expect_stb(OP_OFF, 1'b1);
    clr();
    p = base;
    p.dpu_done_l = 1'b1;
    bus(1, 4'hF, 16'h0000, p, q);
    expect_stb(OP_TXON, 1'b1);
    expect_stb(OP_OFF, 1'b0);
    $display("bind test done");
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    pin = '0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    stat = '0;
    seen_clr = 1'b0;
    mismatches = 0;
    n_compared = 0;
    base = '0;
    base.match_en = 1'b1;
    // Idle and enable-cleared levels high through reset must not flag
    evt = base;
    evt.radio_idle = 1'b1;
    evt.rxen_zero = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_flags();
    t_status();
    t_strobes();
    t_buffer();
    t_pins();
    t_bind();
    conclude();
  end

  initial begin
    #500us;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
endmodule
